// *** verilog/otpb_ctrl.sv ***
// host sequencer that burns and verifies the sensor's fuse memory
`timescale 1ns/1ps
`include "otpb_map.svh"
module otpb_ctrl #(
  parameter int unsigned     PWR_OFF_CYC = `OTPB_PWR_OFF_US * `OTPB_CLK_MHZ,
  parameter int unsigned     PWR_UP_CYC  = `OTPB_PWR_UP_US * `OTPB_CLK_MHZ,
  parameter logic [39:0]     GUARD_CYC   = 40'(`OTPB_GUARD_S) * 40'(`OTPB_CLK_MHZ) * 40'd1000000
) (
  input  wire logic        CLOCK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  output logic      [31:0] REG_RDATA_OUT,
  output logic             IRQ_OUT,
  output logic             DEV_PWR_EN_OUT,
  output logic             DEV_REQ_OUT,
  output logic             DEV_WE_OUT,
  output logic      [13:0] DEV_ADDR_OUT,
  output logic      [15:0] DEV_WDATA_OUT,
  input  wire logic        DEV_ACK_IN,
  input  wire logic [15:0] DEV_RDATA_IN
);
  otpb_pkg::otpb_state_e state_ff, nxt_state;
  otpb_pkg::otpb_stage_t stage_ff;
  logic [1:0]  idx_ff;
  logic [31:0] tmr_ff;
  logic [39:0] guard_ff;
  logic [7:0]  cfg1_ff, cfg2_ff;
  logic [13:0] angle_ff;
  logic        mism_ff, burned_ff, pass_ff, fail_ff, stage1_ok_ff, cleared_ff, gb_ff;
  logic [1:0]  irq_stat_ff, irq_en_ff;
  logic        req_ff, we_ff;
  logic [13:0] addr_ff;
  logic [15:0] wdata_ff;
  logic        acc, acc_we;
  logic [13:0] acc_addr;
  logic [15:0] acc_wdata;
  logic        fire, busy, start, rd_mism, gto;
  logic [13:0] chk_addr;
  logic [7:0]  chk_exp, chk_mask;

  assign fire  = req_ff && DEV_ACK_IN;
  assign busy  = (state_ff != otpb_pkg::ST_IDLE);
  assign start = REG_WR_IN && (REG_ADDR_IN == `OTPB_R_CTRL) && REG_WDATA_IN[`OTPB_CTRL_START];
  assign gto   = (guard_ff >= GUARD_CYC);

  // comparison target for each of the four read-back words
  always_comb begin
    chk_addr = `OTPB_DEV_ZH;
    chk_exp  = angle_ff[13:6];
    chk_mask = 8'hff;
    case (idx_ff)
      2'd0: begin
        chk_addr = `OTPB_DEV_ZH;
        chk_exp  = angle_ff[13:6];
      end
      2'd1: begin
        chk_addr = `OTPB_DEV_ZL;
        chk_exp  = {2'h0, angle_ff[5:0]};
      end
      2'd2: begin
        chk_addr = `OTPB_DEV_CFG1;
        chk_exp  = cfg1_ff;
        chk_mask = `OTPB_FACTORY_MASK; // R5 R12 R14
      end
      default: begin
        chk_addr = `OTPB_DEV_CFG2;
        chk_exp  = cfg2_ff;
      end
    endcase
  end
  assign rd_mism = ((DEV_RDATA_IN[7:0] ^ chk_exp) & chk_mask) != 8'h00; // R5 R12 R14

  // device access requested by the current state
  always_comb begin
    acc       = 1'b1;
    acc_we    = 1'b1;
    acc_addr  = `OTPB_DEV_PROG;
    acc_wdata = 16'h0000;
    case (state_ff)
      otpb_pkg::ST_WR_CFG1: begin
        acc_addr  = `OTPB_DEV_CFG1;
        acc_wdata = {8'h00, cfg1_ff & `OTPB_FACTORY_MASK}; // R1 R2
      end
      otpb_pkg::ST_WR_CFG2: begin
        acc_addr  = `OTPB_DEV_CFG2;
        acc_wdata = {8'h00, cfg2_ff}; // R1
      end
      otpb_pkg::ST_RD_ANGLE: begin
        acc_we   = 1'b0;
        acc_addr = `OTPB_DEV_ANGLE; // R3
      end
      otpb_pkg::ST_WR_ZL: begin
        acc_addr  = `OTPB_DEV_ZL;
        acc_wdata = {10'h000, angle_ff[5:0]}; // R4
      end
      otpb_pkg::ST_WR_ZH: begin
        acc_addr  = `OTPB_DEV_ZH;
        acc_wdata = {8'h00, angle_ff[13:6]}; // R4
      end
      otpb_pkg::ST_RD_CHK: begin
        acc_we   = 1'b0;
        acc_addr = chk_addr;
      end
      otpb_pkg::ST_WR_EN:     acc_wdata = `OTPB_PROG_EN; // R6
      otpb_pkg::ST_WR_BURN:   acc_wdata = `OTPB_PROG_BURN; // R7
      otpb_pkg::ST_POLL:      acc_we = 1'b0; // R8
      otpb_pkg::ST_CLEAR:     acc_addr = chk_addr; // R9
      otpb_pkg::ST_WR_GB:     acc_wdata = `OTPB_PROG_GB; // R10
      otpb_pkg::ST_WR_RELOAD: acc_wdata = `OTPB_PROG_RELOAD; // R11
      default:                acc = 1'b0;
    endcase
  end

  // request held until acknowledged, then one idle cycle before the next
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      req_ff   <= 1'b0;
      we_ff    <= 1'b0;
      addr_ff  <= 14'h0000;
      wdata_ff <= 16'h0000;
    end else begin
      req_ff   <= acc && !fire;
      we_ff    <= acc_we;
      addr_ff  <= acc_addr;
      wdata_ff <= acc_wdata;
    end
  end
  assign DEV_REQ_OUT   = req_ff;
  assign DEV_WE_OUT    = we_ff;
  assign DEV_ADDR_OUT  = addr_ff;
  assign DEV_WDATA_OUT = wdata_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      otpb_pkg::ST_IDLE:
        if (start && !burned_ff) nxt_state = otpb_pkg::ST_PWR_OFF; // R13
      otpb_pkg::ST_PWR_OFF:
        if (tmr_ff >= PWR_OFF_CYC - 1) nxt_state = otpb_pkg::ST_PWR_UP;
      otpb_pkg::ST_PWR_UP:
        if (tmr_ff >= PWR_UP_CYC - 1)
          nxt_state = (stage_ff == 2'd3) ? otpb_pkg::ST_RD_CHK : otpb_pkg::ST_WR_CFG1; // R14
      otpb_pkg::ST_WR_CFG1:  if (fire) nxt_state = otpb_pkg::ST_WR_CFG2;
      otpb_pkg::ST_WR_CFG2:  if (fire) nxt_state = otpb_pkg::ST_RD_ANGLE;
      otpb_pkg::ST_RD_ANGLE: if (fire) nxt_state = otpb_pkg::ST_WR_ZL;
      otpb_pkg::ST_WR_ZL:    if (fire) nxt_state = otpb_pkg::ST_WR_ZH;
      otpb_pkg::ST_WR_ZH:    if (fire) nxt_state = otpb_pkg::ST_RD_CHK;
      otpb_pkg::ST_RD_CHK:   if (fire && idx_ff == 2'd3) nxt_state = otpb_pkg::ST_CHK_END;
      otpb_pkg::ST_CHK_END: begin
        if (mism_ff || (stage_ff == 2'd2 && gto)) nxt_state = otpb_pkg::ST_FAIL; // R13 R15 R16
        else if (stage_ff == 2'd1) nxt_state = otpb_pkg::ST_WR_EN; // R6
        else if (stage_ff == 2'd2) nxt_state = otpb_pkg::ST_PWR_OFF; // R14
        else nxt_state = otpb_pkg::ST_PASS; // R14
      end
      otpb_pkg::ST_WR_EN:   if (fire) nxt_state = otpb_pkg::ST_WR_BURN;
      otpb_pkg::ST_WR_BURN: if (fire) nxt_state = otpb_pkg::ST_POLL;
      otpb_pkg::ST_POLL:
        if (fire && DEV_RDATA_IN == `OTPB_PROG_DONE) nxt_state = otpb_pkg::ST_CLEAR; // R8
      otpb_pkg::ST_CLEAR:     if (fire && idx_ff == 2'd3) nxt_state = otpb_pkg::ST_WR_GB;
      otpb_pkg::ST_WR_GB:     if (fire) nxt_state = otpb_pkg::ST_WR_RELOAD;
      otpb_pkg::ST_WR_RELOAD: if (fire) nxt_state = otpb_pkg::ST_RD_CHK; // R12
      otpb_pkg::ST_PASS:      nxt_state = otpb_pkg::ST_IDLE;
      otpb_pkg::ST_FAIL:      nxt_state = otpb_pkg::ST_IDLE;
      default:                nxt_state = otpb_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) state_ff <= otpb_pkg::ST_IDLE;
    else state_ff <= nxt_state;
  end

  // stage, word index, power timer and power switch
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      stage_ff       <= 2'd0;
      idx_ff         <= 2'd0;
      tmr_ff         <= 32'h0;
      DEV_PWR_EN_OUT <= 1'b1;
    end else begin
      if (nxt_state != state_ff) tmr_ff <= 32'h0;
      else tmr_ff <= tmr_ff + 32'h1;
      if (nxt_state != state_ff) idx_ff <= 2'd0;
      else if (fire) idx_ff <= idx_ff + 2'd1;
      if (state_ff == otpb_pkg::ST_IDLE && nxt_state == otpb_pkg::ST_PWR_OFF) stage_ff <= 2'd1;
      else if (state_ff == otpb_pkg::ST_WR_RELOAD && fire) stage_ff <= 2'd2;
      else if (state_ff == otpb_pkg::ST_CHK_END && nxt_state == otpb_pkg::ST_PWR_OFF)
        stage_ff <= 2'd3;
      DEV_PWR_EN_OUT <= (nxt_state != otpb_pkg::ST_PWR_OFF); // R1 R14
    end
  end

  // captured angle, mismatch accumulation and sequence flags
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      angle_ff     <= 14'h0000;
      mism_ff      <= 1'b0;
      burned_ff    <= 1'b0;
      stage1_ok_ff <= 1'b0;
      cleared_ff   <= 1'b0;
      gb_ff        <= 1'b0;
      guard_ff     <= 40'h0;
    end else begin
      if (state_ff == otpb_pkg::ST_RD_ANGLE && fire) angle_ff <= DEV_RDATA_IN[13:0]; // R3
      if (state_ff != otpb_pkg::ST_RD_CHK && nxt_state == otpb_pkg::ST_RD_CHK) mism_ff <= 1'b0;
      else if (state_ff == otpb_pkg::ST_RD_CHK && fire && rd_mism) mism_ff <= 1'b1; // R5 R12 R14
      if (state_ff == otpb_pkg::ST_CHK_END && stage_ff == 2'd1 && !mism_ff)
        stage1_ok_ff <= 1'b1; // R6
      else if (state_ff == otpb_pkg::ST_IDLE) stage1_ok_ff <= 1'b0;
      if (state_ff == otpb_pkg::ST_WR_BURN && fire) burned_ff <= 1'b1; // R13
      if (state_ff == otpb_pkg::ST_CLEAR && fire && idx_ff == 2'd3) cleared_ff <= 1'b1; // R9
      else if (state_ff == otpb_pkg::ST_IDLE) cleared_ff <= 1'b0;
      if (state_ff == otpb_pkg::ST_WR_GB && fire) gb_ff <= 1'b1; // R10
      else if (state_ff == otpb_pkg::ST_PWR_OFF) gb_ff <= 1'b0; // R15
      if (state_ff == otpb_pkg::ST_WR_BURN) guard_ff <= 40'h0; // R15
      else if (!gto) guard_ff <= guard_ff + 40'h1;
    end
  end

  // software registers
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cfg1_ff <= 8'h00;
      cfg2_ff <= 8'h00;
      pass_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else begin
      if (REG_WR_IN && !busy && REG_ADDR_IN == `OTPB_R_CFG1) cfg1_ff <= REG_WDATA_IN[7:0];
      if (REG_WR_IN && !busy && REG_ADDR_IN == `OTPB_R_CFG2) cfg2_ff <= REG_WDATA_IN[7:0];
      if (state_ff == otpb_pkg::ST_IDLE && nxt_state == otpb_pkg::ST_PWR_OFF) begin
        pass_ff <= 1'b0;
        fail_ff <= 1'b0;
      end else begin
        if (state_ff == otpb_pkg::ST_PASS) pass_ff <= 1'b1; // R14 R16
        if (state_ff == otpb_pkg::ST_FAIL) fail_ff <= 1'b1; // R16
      end
    end
  end

  // sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      irq_stat_ff <= 2'b00;
      irq_en_ff   <= 2'b00;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~((REG_WR_IN && REG_ADDR_IN == `OTPB_R_IRQ_CLR) ?
                     REG_WDATA_IN[1:0] : 2'b00))
                     | {state_ff == otpb_pkg::ST_FAIL, state_ff == otpb_pkg::ST_PASS};
      if (REG_WR_IN && REG_ADDR_IN == `OTPB_R_IRQ_EN) irq_en_ff <= REG_WDATA_IN[1:0];
    end
  end
  assign IRQ_OUT = |(irq_stat_ff & irq_en_ff);

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) REG_RDATA_OUT <= 32'h0;
    else if (!REG_RD_IN) REG_RDATA_OUT <= 32'h0;
    else begin
      case (REG_ADDR_IN)
        `OTPB_R_CFG1:     REG_RDATA_OUT <= {24'h0, cfg1_ff};
        `OTPB_R_CFG2:     REG_RDATA_OUT <= {24'h0, cfg2_ff};
        `OTPB_R_STATUS:   REG_RDATA_OUT <= {21'h0, state_ff, stage_ff, burned_ff,
                                            fail_ff, pass_ff, busy};
        `OTPB_R_ANGLE:    REG_RDATA_OUT <= {18'h0, angle_ff};
        `OTPB_R_IRQ_STAT: REG_RDATA_OUT <= {30'h0, irq_stat_ff};
        `OTPB_R_IRQ_EN:   REG_RDATA_OUT <= {30'h0, irq_en_ff};
        default:          REG_RDATA_OUT <= 32'h0;
      endcase
    end
  end

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);

  logic dev_wr;
  assign dev_wr = req_ff && we_ff;
  sequence s_burn_req;
    dev_wr && addr_ff == `OTPB_DEV_PROG && wdata_ff == `OTPB_PROG_BURN;
  endsequence
  sequence s_reload_req;
    dev_wr && addr_ff == `OTPB_DEV_PROG && wdata_ff == `OTPB_PROG_RELOAD;
  endsequence

  req_held_a: assert property (req_ff && !DEV_ACK_IN |=> req_ff && $stable(addr_ff)) // R8
    else $error("device request dropped before acknowledge");
  factory_bit_a: assert property (dev_wr && addr_ff == `OTPB_DEV_CFG1 |-> !wdata_ff[0]) // R2
    else $error("factory bit written as one");
  // the clear step also writes this address, so only the staging state is checked
  zero_split_a: assert property (dev_wr && state_ff == otpb_pkg::ST_WR_ZH && addr_ff == `OTPB_DEV_ZH
                                 |-> wdata_ff == {8'h00, angle_ff[13:6]}) // R4
    else $error("zero offset high word wrong");
  access_gate_a: assert property (dev_wr && addr_ff == `OTPB_DEV_PROG && wdata_ff == `OTPB_PROG_EN |-> stage1_ok_ff) // R6
    else $error("fuse access enabled without first match");
  single_burn_a: assert property (s_burn_req |-> !burned_ff) // R13
    else $error("second burn attempted");
  burn_poll_a: assert property (s_burn_req ##1 fire |=> ##[1:2] (req_ff && !we_ff && addr_ff == `OTPB_DEV_PROG)) // R8
    else $error("no poll after burn");
  reload_order_a: assert property (s_reload_req |-> gb_ff && cleared_ff) // R9 R10 R11
    else $error("reload before clear and guard band select");
  pass_cause_a: assert property ($rose(pass_ff) |-> $past(stage_ff, 2) == 2'd3 && !$past(mism_ff, 2)) // R14
    else $error("pass without clean third compare");
  pwr_off_a: assert property ($fell(DEV_PWR_EN_OUT) |-> !DEV_PWR_EN_OUT[*8]) // R14
    else $error("power off too short");
  irq_set_a: assert property (state_ff == otpb_pkg::ST_FAIL |=> irq_stat_ff[`OTPB_IRQ_FAIL]) // R16
    else $error("fail event lost");

  // completion seen on a poll read moves on to the clear step
  sequence s_poll_done;
    state_ff == otpb_pkg::ST_POLL && fire && DEV_RDATA_IN == `OTPB_PROG_DONE;
  endsequence
  poll_done_a: assert property (s_poll_done |=> state_ff == otpb_pkg::ST_CLEAR) // R8
    else $error("burn completion not followed by clear");

  clear_zero_a: assert property (dev_wr && state_ff == otpb_pkg::ST_CLEAR
                                 |-> wdata_ff == 16'h0000) // R9
    else $error("volatile copy cleared with nonzero data");

  reload_next_a: assert property (s_reload_req and DEV_ACK_IN
                                  |=> state_ff == otpb_pkg::ST_RD_CHK) // R11 R12
    else $error("no read back after reload");

  // a first-stage mismatch must end the run before any fuse access
  abort_early_a: assert property (state_ff == otpb_pkg::ST_CHK_END && stage_ff == 2'd1 && mism_ff
                                  |=> state_ff == otpb_pkg::ST_FAIL) // R16
    else $error("pre burn mismatch did not abort");

  guard_late_a: assert property (state_ff == otpb_pkg::ST_CHK_END && stage_ff == 2'd2 && gto
                                 |=> state_ff == otpb_pkg::ST_FAIL) // R15
    else $error("guard band check accepted too late");

  start_lock_a: assert property (state_ff == otpb_pkg::ST_IDLE && burned_ff
                                 |=> state_ff == otpb_pkg::ST_IDLE) // R13
    else $error("sequence restarted after a burn");

  fail_flag_a: assert property (state_ff == otpb_pkg::ST_FAIL |=> fail_ff) // R16
    else $error("fail result not reported");

  pass_flag_a: assert property (state_ff == otpb_pkg::ST_PASS |=> pass_ff) // R14 R16
    else $error("pass result not reported");

  // one idle cycle on the device link after every acknowledge
  req_gap_a: assert property (fire |=> !req_ff)
    else $error("device request not dropped after acknowledge");

  rdata_idle_a: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 32'h0)
    else $error("read data left standing");
endmodule

// *** inc/otpb_map.svh ***
// constants for the fuse burn and verify sequencer
// Operation
// R1 - write both config words after power cycle
// R2 - stage config word one with bit 0 zero
// R3 - read measured angle at zero position
// R4 - split angle into low and high offsets
// R5 - read back four words, compare, skip factory bit
// R6 - enable fuse access only after first match
// R7 - start burn by setting burn start bit
// R8 - poll program control until done value
// R9 - clear every volatile copy location to zero
// R10 - then select the guard band
// R11 - reload fuses into volatile copy
// R12 - second compare under guard band, mandatory
// R13 - guard band failure: never burn again
// R14 - third compare after new power cycle
// R15 - guard band only within sequence, one hour
// R16 - abort before burn on mismatch; report result
`ifndef OTPB_MAP_SVH
`define OTPB_MAP_SVH
`define OTPB_DEV_ZH       14'h0016
`define OTPB_DEV_ZL       14'h0017
`define OTPB_DEV_CFG1     14'h0018
`define OTPB_DEV_CFG2     14'h0019
`define OTPB_DEV_PROG     14'h0003
`define OTPB_DEV_ANGLE    14'h3fff
`define OTPB_PROG_EN      16'h0001
`define OTPB_PROG_RELOAD  16'h0004
`define OTPB_PROG_BURN    16'h0008
`define OTPB_PROG_GB      16'h0040
`define OTPB_PROG_DONE    16'h0001
`define OTPB_FACTORY_MASK 8'hfe
`define OTPB_R_CTRL       8'h00
`define OTPB_R_CFG1       8'h04
`define OTPB_R_CFG2       8'h08
`define OTPB_R_STATUS     8'h0c
`define OTPB_R_ANGLE      8'h10
`define OTPB_R_IRQ_STAT   8'h14
`define OTPB_R_IRQ_CLR    8'h18
`define OTPB_R_IRQ_EN     8'h1c
`define OTPB_CTRL_START   0
`define OTPB_IRQ_PASS     0
`define OTPB_IRQ_FAIL     1
`define OTPB_CLK_MHZ      25
`define OTPB_PWR_OFF_US   100
`define OTPB_PWR_UP_US    1000
`define OTPB_GUARD_S      3600
`endif

// *** inc/otpb_pkg.sv ***
// types for the fuse burn and verify sequencer
package otpb_pkg;
  typedef enum logic [4:0] {
    ST_IDLE, ST_PWR_OFF, ST_PWR_UP, ST_WR_CFG1, ST_WR_CFG2, ST_RD_ANGLE,
    ST_WR_ZL, ST_WR_ZH, ST_RD_CHK, ST_CHK_END, ST_WR_EN, ST_WR_BURN,
    ST_POLL, ST_CLEAR, ST_WR_GB, ST_WR_RELOAD, ST_PASS, ST_FAIL
  } otpb_state_e;
  typedef logic [1:0] otpb_stage_t;
endpackage

// *** testbench/otpb_dev_model.sv ***
// behavioural sensor: volatile copy, fuses, program control and angle
`timescale 1ns/1ps
`include "otpb_map.svh"
module otpb_dev_model #(
  parameter logic [13:0] ANGLE = 14'h2a5b
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        pwr_in,
  input  wire logic        req_in,
  input  wire logic        we_in,
  input  wire logic [13:0] addr_in,
  input  wire logic [15:0] wdata_in,
  output logic             ack_out,
  output logic      [15:0] rdata_out,
  input  wire logic [3:0]  dly_in,
  input  wire logic [7:0]  poll_in,
  input  wire logic [1:0]  fault_in,
  output logic      [31:0] fuse_out,
  output int               burns_out,
  output logic             order_err_out
);
  logic [31:0] vol = 0;
  logic [15:0] last = 0;
  logic [15:0] val;
  logic [13:0] la = 0;
  logic [1:0]  ix;
  logic        en = 0, gb = 0, hit, pq = 0;
  int          cnt = 0, busy = 0;
  assign ix = 2'(addr_in - `OTPB_DEV_ZH);
  assign hit = addr_in >= `OTPB_DEV_ZH && addr_in <= `OTPB_DEV_CFG2;
  assign ack_out = req_in && pwr_in && cnt == int'(dly_in);
  always_comb begin
    val = 16'h0000;
    if (addr_in == `OTPB_DEV_ANGLE) val = {2'b00, ANGLE};
    if (addr_in == `OTPB_DEV_PROG) val = busy != 0 ? 16'h0008 : `OTPB_PROG_DONE;
    // factory bit of config word one always reads back as one
    if (hit) val = {8'h00, vol[8*(3-ix) +: 8] | 8'(ix == 2'd2)};
  end
  // released data line shows the inverse of the last answer
  assign rdata_out = ack_out ? val : ~last;
  always @(posedge clk_in) begin
    cnt <= (req_in && !ack_out) ? cnt + 1 : 0;
    pq <= req_in && !ack_out;
    la <= addr_in;
    if (pq && addr_in != la) order_err_out <= 1'b1;
    if (req_in && !pwr_in) order_err_out <= 1'b1;
    if (ack_out) last <= val;
    if (!pwr_in) begin
      vol <= fuse_out ^ 32'((fault_in == 2'd3) && burns_out > 0);
      en <= 1'b0;
      gb <= 1'b0;
    end else if (ack_out && we_in) begin
      if (hit) vol[8*(3-ix) +: 8] <= wdata_in[7:0] ^ 8'(fault_in == 2'd1 && ix == 2'd3);
      if (addr_in == `OTPB_DEV_PROG) begin
        if (wdata_in[0]) en <= 1'b1;
        if (wdata_in[6]) gb <= 1'b1;
        if (wdata_in[3]) begin
          if (!en) order_err_out <= 1'b1;
          burns_out <= burns_out + 1;
          fuse_out <= vol;
          busy <= int'(poll_in);
        end
        if (wdata_in[2]) begin
          if (!gb || vol != 0) order_err_out <= 1'b1;
          vol <= fuse_out ^ 32'(fault_in == 2'd2);
        end
      end
    end else if (ack_out && addr_in == `OTPB_DEV_PROG && busy != 0) busy <= busy - 1;
    if (!rst_n_in) begin
      burns_out <= 0;
      fuse_out <= 0;
      order_err_out <= 1'b0;
    end
  end
endmodule

// *** testbench/test_otpb_ctrl.sv ***
// bench for the fuse burn and verify sequencer
`timescale 1ns/1ps
`include "otpb_map.svh"
module test_otpb_ctrl;
  typedef struct {
    logic [7:0] c1, c2; logic [3:0] dly; logic [7:0] poll;
    logic [1:0] flt, en; logic ok; int burns;
  } otpb_row_s;
  localparam logic [13:0] ANG = 14'h2a5b;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, ack, irq, pwr, req, we, oerr;
  logic [7:0]  addr = 0, poll = 0;
  logic [31:0] wdata = 0, rdata, fuse, d;
  logic [13:0] daddr;
  logic [15:0] dwd, drd;
  logic [3:0]  dly = 0;
  logic [1:0]  flt = 0;
  int          burns, err_count = 0, num_checks = 0;
  otpb_row_s rows[5] = '{
    '{8'h5a, 8'h3c, 4'h0, 8'h02, 2'd0, 2'b01, 1'b1, 1},
    '{8'hff, 8'h81, 4'h3, 8'h02, 2'd1, 2'b10, 1'b0, 0},
    '{8'ha5, 8'h00, 4'h1, 8'h02, 2'd2, 2'b11, 1'b0, 1},
    '{8'h01, 8'hff, 4'h2, 8'h02, 2'd3, 2'b00, 1'b0, 1},
    '{8'h3c, 8'h5a, 4'h3, 8'hff, 2'd0, 2'b10, 1'b0, 1}};
  always #20 clk = ~clk;
  otpb_ctrl #(.PWR_OFF_CYC(10), .PWR_UP_CYC(20), .GUARD_CYC(40'd1000)) u_otpb_ctrl (
    .CLOCK_IN(clk), .RESETN_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .IRQ_OUT(irq),
    .DEV_PWR_EN_OUT(pwr), .DEV_REQ_OUT(req), .DEV_WE_OUT(we), .DEV_ADDR_OUT(daddr),
    .DEV_WDATA_OUT(dwd), .DEV_ACK_IN(ack), .DEV_RDATA_IN(drd));
  otpb_dev_model #(.ANGLE(ANG)) u_otpb_dev_model (
    .clk_in(clk), .rst_n_in(rst_n), .pwr_in(pwr), .req_in(req), .we_in(we),
    .addr_in(daddr), .wdata_in(dwd), .ack_out(ack), .rdata_out(drd), .dly_in(dly),
    .poll_in(poll), .fault_in(flt), .fuse_out(fuse), .burns_out(burns),
    .order_err_out(oerr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    #1 chk({pwr, req, irq}, 32'h4);
    @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #2000000;
    err_count++;
    summarize();
  end
  initial begin
    foreach (rows[i]) begin
      dly <= rows[i].dly;
      poll <= rows[i].poll;
      flt <= rows[i].flt;
      do_reset();
      wreg(`OTPB_R_CFG1, {24'h0, rows[i].c1});
      wreg(`OTPB_R_CFG2, {24'h0, rows[i].c2});
      wreg(`OTPB_R_IRQ_EN, {30'h0, rows[i].en});
      wreg(`OTPB_R_CTRL, 32'h1);
      wreg(`OTPB_R_CFG1, 32'h11);
      rreg(`OTPB_R_CFG1, d);
      chk(d, {24'h0, rows[i].c1});
      d = 0;
      for (int n = 0; n < 3000 && d[2:1] == 2'b00; n++) rreg(`OTPB_R_STATUS, d);
      chk(d[2:1], {!rows[i].ok, rows[i].ok});
      rreg(`OTPB_R_IRQ_STAT, d);
      chk(d, {30'h0, !rows[i].ok, rows[i].ok});
      chk(irq, 32'(|(d[1:0] & rows[i].en)));
      chk(burns, rows[i].burns);
      chk(fuse, rows[i].burns == 0 ? 32'h0 :
          {ANG[13:6], 2'b00, ANG[5:0], rows[i].c1 & 8'hfe, rows[i].c2});
      chk(oerr, 0);
      rreg(`OTPB_R_ANGLE, d);
      chk(d, {18'h0, ANG});
      wreg(`OTPB_R_CTRL, 32'h1);
      repeat (60) @(posedge clk);
      rreg(`OTPB_R_STATUS, d);
      chk(d[0], 32'(rows[i].burns == 0));
      chk(d[3], 32'(rows[i].burns != 0));
      chk(burns, rows[i].burns);
      $display("row %0d done", i);
    end
    wreg(`OTPB_R_IRQ_CLR, 32'h3);
    rreg(`OTPB_R_IRQ_STAT, d);
    chk(d, 0);
    chk(irq, 0);
    rreg(8'h20, d);
    chk(d, 0);
    rreg(`OTPB_R_CFG1, d);
    @(posedge clk);
    #1 chk(rdata, 0);
    wreg(8'h24, 32'hff);
    rreg(`OTPB_R_CFG1, d);
    chk(d, {24'h0, rows[4].c1});
    $display("register cases done");
    summarize();
  end
endmodule
